// ===== aic_pkg.sv
// Package with constants for the analog input conditioning block.
package aic_pkg;
  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] OFS_AIN1_LEVEL_SELECT = 8'h00;
  localparam logic [7:0] OFS_AIN1_FUNCTION_SELECT = 8'h04;
  localparam logic [7:0] OFS_AIN1_GAIN = 8'h08;
  localparam logic [7:0] OFS_AIN1_BIAS = 8'h0c;
  localparam logic [7:0] OFS_AIN2_LEVEL_SELECT = 8'h10;
  localparam logic [7:0] OFS_AIN2_FUNCTION_SELECT = 8'h14;
  localparam logic [7:0] OFS_AIN2_GAIN = 8'h18;
  localparam logic [7:0] OFS_AIN2_BIAS = 8'h1c;
  localparam logic [7:0] OFS_AIN_FILTER_TC = 8'h20;
  localparam logic [7:0] OFS_AIN_ENABLE_SELECT = 8'h24;
  localparam logic [7:0] OFS_CONTACT_INPUT_FUNCTION = 8'h28;
  localparam logic [7:0] OFS_MAX_OUTPUT_FREQUENCY = 8'h2c;
  localparam logic [7:0] OFS_AIN1_LEVEL = 8'h30;
  localparam logic [7:0] OFS_AIN2_LEVEL = 8'h34;
  localparam logic [7:0] OFS_FREQ_REF = 8'h38;
  localparam logic [7:0] OFS_STATUS = 8'h3c;
  // Percent values are signed, in units of 0.1 percent.
  localparam logic signed [15:0] PCT_MAX = 16'sd9999;
  localparam logic signed [15:0] PCT_MIN = -16'sd9999;
  localparam logic signed [15:0] PCT_100 = 16'sd1000;
  localparam logic signed [15:0] RST_GAIN = 16'sd1000;
  localparam logic signed [15:0] RST_BIAS = 16'sd0;
  // Level select codes and their reset values.
  localparam logic LVL_UNIPOLAR = 1'b0;
  localparam logic LVL_BIPOLAR = 1'b1;
  localparam logic RST_AIN1_LEVEL = 1'b0;
  localparam logic RST_AIN2_LEVEL = 1'b1;
  // Function select codes, ranges and reset value.
  localparam logic [7:0] FN_FREQ_BIAS = 8'h00;
  localparam logic [7:0] FN_FREQ_GAIN = 8'h01;
  localparam logic [7:0] FN_THROUGH = 8'h0f;
  localparam logic [7:0] FN_THROUGH2 = 8'h1f;
  localparam logic [7:0] FN_AIN2_MAX = 8'h32;
  localparam logic [7:0] RST_FUNCTION = 8'h00;
  // Enable select codes and reset value.
  localparam logic [1:0] ENS_ALL = 2'h1;
  localparam logic [1:0] ENS_AIN2 = 2'h2;
  localparam logic [1:0] ENS_BOTH = 2'h3;
  localparam logic [1:0] RST_ENABLE_SELECT = 2'h3;
  // Contact input function code that means analog input enable.
  localparam logic [7:0] CIF_AIN_ENABLE = 8'h0c;
  localparam logic [7:0] RST_CONTACT_FUNCTION = 8'h00;
  // Maximum output frequency in 0.01 Hz, reset value.
  localparam logic [15:0] RST_MAX_FREQ = 16'd6000;
  // Filter time constant in 10 ms units: range 0..200, reset 3.
  localparam logic [7:0] TC_MAX = 8'd200;
  localparam logic [7:0] RST_FILTER_TC = 8'd3;
  // Clock and filter sample period.
  localparam int CLK_HZ = 10000000;
  localparam int SAMPLE_US = 100;
  localparam int SAMPLE_CYC = CLK_HZ / 1000000 * SAMPLE_US;
  localparam int TC_UNIT_MS = 10;
  // Full-scale converter code for 10 V.
  localparam logic signed [15:0] ADC_FS = 16'sd2047;
endpackage : aic_pkg

// ===== aic_cfg_if.sv
// Interface carrying one channel's settings and sample to its scaler.
`timescale 1ns/1ps
interface aic_cfg_if;
  // Signed converter sample, full scale is plus or minus 10 V.
  logic signed [11:0] sample;
  // Gain and bias in 0.1 percent.
  logic signed [15:0] gain;
  logic signed [15:0] bias;
  // Level selection code.
  logic level;
  // Scaled, clamped result in 0.1 percent.
  logic signed [15:0] scaled;
  modport top (output sample, gain, bias, level, input scaled);
  modport scaler (input sample, gain, bias, level, output scaled);
endinterface : aic_cfg_if

// ===== aic_scaler.sv
// Gain, bias and unipolar clamp for one analog input channel.
`timescale 1ns/1ps
module aic_scaler (
  input wire hclk,
  input wire hresetn,
  aic_cfg_if.scaler cfg
);
  import aic_pkg::*;
  // Raw linear result before clamping, wide enough to not overflow.
  logic signed [31:0] lin;
  // Result limited to the legal percent range.
  logic signed [15:0] sat;

  // Line through bias at 0 V and gain at 10 V.
  always_comb begin
    lin = 32'(cfg.bias) + 32'((32'(cfg.gain) - 32'(cfg.bias)) *
          32'(cfg.sample) / 32'(ADC_FS));
    if (lin > 32'(PCT_MAX)) begin
      sat = PCT_MAX;
    end else if (lin < 32'(PCT_MIN)) begin
      sat = PCT_MIN;
    end else begin
      sat = lin[15:0];
    end
  end

  // Register the result; unipolar inputs lose negative values.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg.scaled <= 16'sh0000;
    end else if (cfg.level == LVL_UNIPOLAR && sat < 0) begin
      cfg.scaled <= 16'sh0000;
    end else begin
      cfg.scaled <= sat;
    end
  end
endmodule : aic_scaler

// ===== aic_top.sv
// Analog input conditioning: scaling, filter, enable and function routing.
`timescale 1ns/1ps
module aic_top (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire signed [11:0] ain1_sample,
  input wire signed [11:0] ain2_sample,
  input wire ain_enable_contact,
  input wire ref_is_analog,
  output logic signed [15:0] freq_ref,
  output logic signed [15:0] ain1_level,
  output logic signed [15:0] ain2_level
);
  import aic_pkg::*;

  // Settings written by software.
  logic ain1_level_select;
  logic ain2_level_select;
  logic [7:0] ain1_function_select;
  logic [7:0] ain2_function_select;
  logic signed [15:0] ain1_gain;
  logic signed [15:0] ain1_bias;
  logic signed [15:0] ain2_gain;
  logic signed [15:0] ain2_bias;
  logic [7:0] ain_filter_tc;
  logic [1:0] ain_enable_select;
  logic [7:0] contact_input_function;
  logic [15:0] max_output_frequency;
  // Latched address phase.
  logic wr_pend;
  logic [7:0] wr_addr;
  // Contact pin synchroniser stages.
  logic cont_s1;
  logic cont_s2;
  logic cont_s3;
  logic cont_on;
  // Sample period divider and its enable pulse.
  logic [15:0] div_cnt;
  logic tick;
  // Filter states, extra fraction bits for slow constants.
  logic signed [31:0] filt1;
  logic signed [31:0] filt2;
  // Enable results for each input.
  logic en1;
  logic en2;
  // Combined analog reference in 0.1 percent and the frequency made from it.
  logic signed [31:0] next_ref_pct;
  logic signed [31:0] next_freq;
  // Signed copy of the maximum output frequency.
  logic signed [31:0] freq_lim;

  aic_cfg_if ch1 ();
  aic_cfg_if ch2 ();

  // Each channel scaler receives its own settings.
  assign ch1.sample = ain1_sample;
  assign ch1.gain = ain1_gain;
  assign ch1.bias = ain1_bias;
  assign ch1.level = ain1_level_select;
  assign ch2.sample = ain2_sample;
  assign ch2.gain = ain2_gain;
  assign ch2.bias = ain2_bias;
  assign ch2.level = ain2_level_select;

  // Input 1 scaler.
  aic_scaler u_sc1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .cfg(ch1.scaler)
  );

  // Input 2 scaler, same scaling with input 2 settings.
  aic_scaler u_sc2 (
    .hclk(hclk),
    .hresetn(hresetn),
    .cfg(ch2.scaler)
  );

  // Clamp a written percent value into the legal range.
  function automatic logic signed [15:0] pct_limit(input logic [31:0] d);
    logic signed [15:0] v;
    v = d[15:0];
    if (v > PCT_MAX) begin
      pct_limit = PCT_MAX;
    end else if (v < PCT_MIN) begin
      pct_limit = PCT_MIN;
    end else begin
      pct_limit = v;
    end
  endfunction

  // Bus slave always ready with OKAY; writes land in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Responses are zero-wait and never an error.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Setting registers with range checks on write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ain1_level_select <= RST_AIN1_LEVEL;
      ain2_level_select <= RST_AIN2_LEVEL;
      ain1_function_select <= RST_FUNCTION;
      ain2_function_select <= RST_FUNCTION;
      ain1_gain <= RST_GAIN;
      ain1_bias <= RST_BIAS;
      ain2_gain <= RST_GAIN;
      ain2_bias <= RST_BIAS;
      ain_filter_tc <= RST_FILTER_TC;
      ain_enable_select <= RST_ENABLE_SELECT;
      contact_input_function <= RST_CONTACT_FUNCTION;
      max_output_frequency <= RST_MAX_FREQ;
    end else if (wr_pend) begin
      unique case (wr_addr)
        OFS_AIN1_LEVEL_SELECT: ain1_level_select <= hwdata[0];
        OFS_AIN2_LEVEL_SELECT: ain2_level_select <= hwdata[0];
        // Input 1 takes every 8-bit code.
        OFS_AIN1_FUNCTION_SELECT: ain1_function_select <= hwdata[7:0];
        OFS_AIN2_FUNCTION_SELECT: begin
          // Codes past the upper end are ignored.
          if (hwdata[7:0] <= FN_AIN2_MAX) begin
            ain2_function_select <= hwdata[7:0];
          end
        end
        OFS_AIN1_GAIN: ain1_gain <= pct_limit(hwdata);
        OFS_AIN1_BIAS: ain1_bias <= pct_limit(hwdata);
        OFS_AIN2_GAIN: ain2_gain <= pct_limit(hwdata);
        OFS_AIN2_BIAS: ain2_bias <= pct_limit(hwdata);
        OFS_AIN_FILTER_TC: begin
          // Constants above 2.00 s saturate at the top.
          ain_filter_tc <= (hwdata[7:0] > TC_MAX) ? TC_MAX
                           : hwdata[7:0];
        end
        OFS_AIN_ENABLE_SELECT: begin
          // Code 0 is out of range and ignored.
          if (hwdata[1:0] != 2'h0) begin
            ain_enable_select <= hwdata[1:0];
          end
        end
        OFS_CONTACT_INPUT_FUNCTION: contact_input_function <= hwdata[7:0];
        OFS_MAX_OUTPUT_FREQUENCY: max_output_frequency <= hwdata[15:0];
        default: begin
          // Read-only and unmapped addresses ignore writes.
        end
      endcase
    end
  end

  // Read data for the next data phase, registered from the address.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        OFS_AIN1_LEVEL_SELECT: hrdata <= {31'h0, ain1_level_select};
        OFS_AIN2_LEVEL_SELECT: hrdata <= {31'h0, ain2_level_select};
        OFS_AIN1_FUNCTION_SELECT: hrdata <= {24'h0, ain1_function_select};
        OFS_AIN2_FUNCTION_SELECT: hrdata <= {24'h0, ain2_function_select};
        OFS_AIN1_GAIN: hrdata <= 32'(ain1_gain);
        OFS_AIN1_BIAS: hrdata <= 32'(ain1_bias);
        OFS_AIN2_GAIN: hrdata <= 32'(ain2_gain);
        OFS_AIN2_BIAS: hrdata <= 32'(ain2_bias);
        OFS_AIN_FILTER_TC: hrdata <= {24'h0, ain_filter_tc};
        OFS_AIN_ENABLE_SELECT: hrdata <= {30'h0, ain_enable_select};
        OFS_CONTACT_INPUT_FUNCTION:
          hrdata <= {24'h0, contact_input_function};
        OFS_MAX_OUTPUT_FREQUENCY: hrdata <= {16'h0, max_output_frequency};
        // Levels stay readable even in through mode.
        OFS_AIN1_LEVEL: hrdata <= 32'(ain1_level);
        OFS_AIN2_LEVEL: hrdata <= 32'(ain2_level);
        OFS_FREQ_REF: hrdata <= 32'(freq_ref);
        OFS_STATUS: hrdata <= {29'h0, cont_on, en2, en1};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // Three-stage synchroniser for the contact pin.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cont_s1 <= 1'b0;
      cont_s2 <= 1'b0;
      cont_s3 <= 1'b0;
      cont_on <= 1'b0;
    end else begin
      cont_s1 <= ain_enable_contact;
      cont_s2 <= cont_s1;
      cont_s3 <= cont_s2;
      if (cont_s2 == cont_s3) begin
        cont_on <= cont_s3;
      end
    end
  end

  // Enables follow the contact only when a contact is so assigned.
  always_comb begin
    if (contact_input_function != CIF_AIN_ENABLE) begin
      en1 = 1'b1;
      en2 = 1'b1;
    end else if (!cont_on) begin
      en1 = 1'b0;
      en2 = 1'b0;
    end else begin
      en1 = (ain_enable_select != ENS_AIN2);
      en2 = 1'b1;
    end
  end

  // Divider making the filter sample enable.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (div_cnt == 16'(SAMPLE_CYC - 1)) begin
      div_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // Filter step: y += (x - y) * Ts / (Ts + tc), per sample period.
  function automatic logic signed [31:0] filt_step(
    input logic signed [31:0] y,
    input logic signed [15:0] x,
    input logic [7:0] tc
  );
    logic signed [31:0] xs;
    logic signed [31:0] den;
    // Fifteen fraction bits keep slow constants from stalling short.
    xs = 32'(x) <<< 15;
    den = 32'(int'(tc) * TC_UNIT_MS * 1000 / SAMPLE_US + 1);
    filt_step = y + (xs - y) / den;
  endfunction

  // Both channels filtered with the shared time constant.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt1 <= 32'sh00000000;
      filt2 <= 32'sh00000000;
    end else if (tick) begin
      filt1 <= filt_step(filt1, ch1.scaled, ain_filter_tc);
      filt2 <= filt_step(filt2, ch2.scaled, ain_filter_tc);
    end
  end

  // Disabled inputs read as zero at the outputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ain1_level <= 16'sh0000;
      ain2_level <= 16'sh0000;
    end else begin
      ain1_level <= en1 ? filt1[30:15] : 16'sh0000;
      ain2_level <= en2 ? filt2[30:15] : 16'sh0000;
    end
  end

  // Maximum frequency as a signed word so that the product below stays signed.
  assign freq_lim = signed'({16'h0000, max_output_frequency});

  // Combine inputs by function code into the analog reference.
  always_comb begin
    next_ref_pct = 32'sh00000000;
    // Bias functions add to the reference.
    if (ain1_function_select == FN_FREQ_BIAS) begin
      next_ref_pct = next_ref_pct + 32'(ain1_level);
    end
    if (ain2_function_select == FN_FREQ_BIAS) begin
      next_ref_pct = next_ref_pct + 32'(ain2_level);
    end
    // Gain functions scale the sum as a fraction of 100 percent.
    if (ain1_function_select == FN_FREQ_GAIN) begin
      next_ref_pct = next_ref_pct * 32'(ain1_level) / 32'(PCT_100);
    end
    if (ain2_function_select == FN_FREQ_GAIN) begin
      next_ref_pct = next_ref_pct * 32'(ain2_level) / 32'(PCT_100);
    end
    // Through-mode codes fall through all branches and add nothing.
    if (!ref_is_analog) begin
      next_ref_pct = 32'sh00000000;
    end
    // Limit to 100 percent first so the product below cannot overflow.
    if (next_ref_pct > 32'(PCT_100)) begin
      next_ref_pct = 32'(PCT_100);
    end else if (next_ref_pct < -32'(PCT_100)) begin
      next_ref_pct = -32'(PCT_100);
    end
    // Percent to frequency; the result never exceeds the maximum.
    next_freq = next_ref_pct * freq_lim / 32'(PCT_100);
  end

  // Signed frequency reference; negative means reverse.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_ref <= 16'sh0000;
    end else begin
      freq_ref <= next_freq[15:0];
    end
  end
endmodule : aic_top

// ===== aic_adc_model.sv
// Converter model that turns terminal millivolts into signed codes.
`timescale 1ns/1ps
module aic_adc_model (
  input wire signed [15:0] mv1,
  input wire signed [15:0] mv2,
  output logic signed [11:0] ain1_sample,
  output logic signed [11:0] ain2_sample
);
  // Full scale of 10000 mV gives code 2047 in either direction.
  assign ain1_sample = 12'(int'(mv1) * 2047 / 10000);
  assign ain2_sample = 12'(int'(mv2) * 2047 / 10000);
endmodule // aic_adc_model

// ===== aic_top_chk.sv
// Checker that watches the ports of aic_top.
`timescale 1ns/1ps
module aic_top_chk (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire signed [15:0] freq_ref,
  input wire signed [15:0] ain1_level,
  input wire signed [15:0] ain2_level
);
  import aic_pkg::*;
  // Write data phase flag and the offset of its address phase.
  logic wr_p;
  logic [7:0] pa;
  // Shadows of settings that the read data and the frequency bound must reflect.
  logic [7:0] tc_s;
  logic [1:0] ens_s;
  logic [15:0] mfq_s;
  // Set once input 1 has been made bipolar.
  logic bip_seen;
  // Follows bus writes, clamping and refusing as the design must.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_p <= 1'b0;
      pa <= 8'h00;
      tc_s <= RST_FILTER_TC;
      ens_s <= RST_ENABLE_SELECT;
      mfq_s <= RST_MAX_FREQ;
      bip_seen <= 1'b0;
    end else begin
      wr_p <= hsel && hready && htrans[1] && hwrite;
      pa <= haddr[7:0];
      if (wr_p && pa == OFS_AIN_FILTER_TC)
        tc_s <= (hwdata[7:0] > TC_MAX) ? TC_MAX : hwdata[7:0];
      if (wr_p && pa == OFS_AIN_ENABLE_SELECT && hwdata[1:0] != 2'h0)
        ens_s <= hwdata[1:0];
      if (wr_p && pa == OFS_MAX_OUTPUT_FREQUENCY)
        mfq_s <= hwdata[15:0];
      if (wr_p && pa == OFS_AIN1_LEVEL_SELECT && hwdata[0])
        bip_seen <= 1'b1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A read address phase followed by its data phase.
  sequence s_rd(logic [7:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a ##1 1'b1;
  endsequence
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("hreadyout low");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  a_out_reset: assert property ($rose(hresetn) |->
    freq_ref == 16'h0000 && ain1_level == 16'h0000 && ain2_level == 16'h0000)
    else $error("outputs not cleared by reset");
  a_unmapped_zero: assert property (hsel && hready && htrans[1] && !hwrite
    && haddr[7:0] >= 8'h40 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_tc_readback: assert property (
    s_rd(OFS_AIN_FILTER_TC) |-> hrdata == {24'h0, tc_s})
    else $error("filter time read back wrong");
  a_ens_readback: assert property (
    s_rd(OFS_AIN_ENABLE_SELECT) |-> hrdata == {30'h0, ens_s})
    else $error("enable select read back wrong");
  a_uni_nonneg: assert property (!bip_seen |-> ain1_level >= 0)
    else $error("unipolar input 1 went negative");
  a_freq_bound: assert property (mfq_s == $past(mfq_s, 3) |->
    int'(freq_ref) <= int'(mfq_s) && -int'(freq_ref) <= int'(mfq_s))
    else $error("frequency beyond maximum");
endmodule // aic_top_chk

bind aic_top aic_top_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .freq_ref(freq_ref), .ain1_level(ain1_level), .ain2_level(ain2_level)
);

// ===== aic_top_tb.sv
// Self-checking testbench for the analog input conditioning block.
`timescale 1ns/1ps
module aic_top_tb;
  import aic_pkg::*;
  // Stimulus, every input given a value at time zero.
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic ain_enable_contact = 1'b0;
  logic ref_is_analog = 1'b1;
  logic signed [15:0] mv1 = 16'h0000;
  logic signed [15:0] mv2 = 16'h0000;
  // Design outputs and converter codes.
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire signed [11:0] ain1_sample;
  wire signed [11:0] ain2_sample;
  wire signed [15:0] freq_ref;
  wire signed [15:0] ain1_level;
  wire signed [15:0] ain2_level;
  logic [31:0] rd;
  int miscompares = 0;
  int num_checks = 0;
  // Offsets set per row: gain1, bias1, gain2, level1, function2.
  logic [7:0] ofs [5] = '{OFS_AIN1_GAIN, OFS_AIN1_BIAS, OFS_AIN2_GAIN,
    OFS_AIN1_LEVEL_SELECT, OFS_AIN2_FUNCTION_SELECT};
  // Rows: mv1, mv2, five settings, then levels and frequency expected.
  int rows [7][10] = '{
    '{10000, 0, 2000, 0, 1000, 0, 0, 2000, 0, 6000},
    '{0, 0, 1000, -250, 1000, 0, 0, 0, 0, 0},
    '{0, 0, 1000, -250, 1000, 1, 0, -250, 0, -1500},
    '{-10000, 10000, 500, 0, 1000, 1, 0, -500, 1000, 3000},
    '{10000, 10000, 800, 0, 500, 1, 1, 800, 500, 2400},
    '{10000, 10000, 800, 0, 500, 1, 15, 800, 500, 4800},
    '{10000, 10000, 600, 0, 500, 1, 31, 600, 500, 3600}};
  // Register reset values for offsets 0x00 to 0x2c.
  int dflt [12] = '{0, 0, 1000, 0, 1, 0, 1000, 0, 3, 3, 0, 6000};

  always #50 hclk = ~hclk;

  aic_adc_model adc (.mv1(mv1), .mv2(mv2), .ain1_sample(ain1_sample),
    .ain2_sample(ain2_sample));

  aic_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ain1_sample(ain1_sample), .ain2_sample(ain2_sample),
    .ain_enable_contact(ain_enable_contact), .ref_is_analog(ref_is_analog),
    .freq_ref(freq_ref), .ain1_level(ain1_level), .ain2_level(ain2_level));

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Compares one register word.
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Compares one analog output.
  task automatic chk_lv(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One single AHB-Lite transfer; read data lands in rd.
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    rd = hrdata;
    if (n >= 40) begin
      miscompares++;
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk_rd(rd, e);
  endtask

  // Waits, bounded, for the filtered outputs to reach their targets.
  task automatic settle(input int e1, input int e2, input int ef);
    int n;
    n = 0;
    while (n < 25000 && !(ain1_level === 16'(e1) &&
      ain2_level === 16'(e2) && freq_ref === 16'(ef))) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 25000) begin
      miscompares++;
      conclude();
    end else begin
      chk_lv(ain1_level, 16'(e1));
      chk_lv(ain2_level, 16'(e2));
      chk_lv(freq_ref, 16'(ef));
    end
  endtask

  task automatic rst();
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  initial begin
    rst();
    wr(OFS_AIN_FILTER_TC, 32'h0);
    for (int i = 0; i < 7; i++) begin
      for (int j = 0; j < 5; j++)
        wr(ofs[j], rows[i][j + 2]);
      mv1 <= 16'(rows[i][0]);
      mv2 <= 16'(rows[i][1]);
      settle(rows[i][7], rows[i][8], rows[i][9]);
    end
    // Second reset, then reset values, clamped and refused writes.
    rst();
    for (int j = 0; j < 12; j++)
      rd_chk(8'(4 * j), dflt[j]);
    wr(OFS_AIN1_GAIN, 32'h2ee0);
    bus(1'b0, OFS_AIN1_GAIN, 32'h0);
    chk_rd({16'h0, rd[15:0]}, 32'h270f);
    wr(OFS_AIN2_BIAS, 32'hffffd120);
    bus(1'b0, OFS_AIN2_BIAS, 32'h0);
    chk_rd({16'h0, rd[15:0]}, 32'hd8f1);
    wr(OFS_AIN_FILTER_TC, 32'hfa);
    rd_chk(OFS_AIN_FILTER_TC, 32'hc8);
    wr(OFS_AIN2_FUNCTION_SELECT, 32'h32);
    wr(OFS_AIN2_FUNCTION_SELECT, 32'h33);
    rd_chk(OFS_AIN2_FUNCTION_SELECT, 32'h32);
    wr(OFS_AIN1_FUNCTION_SELECT, 32'hff);
    rd_chk(OFS_AIN1_FUNCTION_SELECT, 32'hff);
    wr(OFS_AIN_ENABLE_SELECT, 32'h2);
    wr(OFS_AIN_ENABLE_SELECT, 32'h0);
    rd_chk(OFS_AIN_ENABLE_SELECT, 32'h2);
    rd_chk(8'h40, 32'h0);
    // Contact enable with both inputs at full scale.
    wr(OFS_AIN1_GAIN, 32'h3e8);
    wr(OFS_AIN2_BIAS, 32'h0);
    wr(OFS_AIN_FILTER_TC, 32'h0);
    wr(OFS_AIN1_FUNCTION_SELECT, 32'h0);
    wr(OFS_AIN2_FUNCTION_SELECT, 32'h0);
    settle(1000, 1000, 6000);
    wr(OFS_CONTACT_INPUT_FUNCTION, {24'h0, CIF_AIN_ENABLE});
    settle(0, 0, 0);
    ain_enable_contact <= 1'b1;
    settle(0, 1000, 6000);
    wr(OFS_AIN_ENABLE_SELECT, 32'h1);
    settle(1000, 1000, 6000);
    // Through mode still leaves the level and status readable.
    wr(OFS_AIN2_FUNCTION_SELECT, 32'h1f);
    rd_chk(OFS_AIN2_LEVEL, 32'h3e8);
    rd_chk(OFS_STATUS, 32'h7);
    rd_chk(OFS_FREQ_REF, 32'h1770);
    // A non-analog reference source removes the analog contribution.
    ref_is_analog <= 1'b0;
    settle(1000, 1000, 0);
    conclude();
  end
endmodule // aic_top_tb
